/* File: kmc_pkg.sv */
// constants shared by the keyboard and mouse port controller
package kmc_pkg;
  // ***************
  // timing
  // ***************
  localparam int CLK_NS      = 40;
  localparam int INHIBIT_NS  = 100000;
  localparam int INHIBIT_CYC = (INHIBIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_NS     = 10000;
  localparam int TICK_CYC    = TICK_NS / CLK_NS;
  // ***************
  // host port map
  // ***************
  localparam logic [7:0] ADR_DATA = 8'h60;
  localparam logic [7:0] ADR_CMD  = 8'h64;
  localparam logic [7:0] ADR_NONE = 8'hFF;
  // ***************
  // mode register
  // ***************
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] MODE_MASK  = 8'h77;
  localparam int MODE_KIE  = 0;
  localparam int MODE_AIE  = 1;
  localparam int MODE_WARM = 2;
  localparam int MODE_KDIS = 4;
  localparam int MODE_ADIS = 5;
  localparam int MODE_XLAT = 6;
  localparam logic [7:0] OUT_RESET = 8'h00;
  // ***************
  // commands
  // ***************
  localparam logic [7:0] CMD_RAM_RD  = 8'h20;
  localparam logic [7:0] CMD_RAM_RDE = 8'h3F;
  localparam logic [7:0] CMD_RAM_WR  = 8'h60;
  localparam logic [7:0] CMD_RAM_WRE = 8'h7F;
  localparam logic [7:0] CMD_AUX_OFF = 8'hA7;
  localparam logic [7:0] CMD_AUX_ON  = 8'hA8;
  localparam logic [7:0] CMD_KBD_OFF = 8'hAD;
  localparam logic [7:0] CMD_KBD_ON  = 8'hAE;
  localparam logic [7:0] CMD_IN_RD   = 8'hC0;
  localparam logic [7:0] CMD_OUT_RD  = 8'hD0;
  localparam logic [7:0] CMD_OUT_WR  = 8'hD1;
  localparam logic [7:0] CMD_AUX_TX  = 8'hD4;
  localparam logic [7:0] RX_PARITY_ERROR_BYTE   = 8'hFF;
  localparam logic [7:0] BREAK_PFX   = 8'hF0;
  // ***************
  // scan-code translation table
  // ***************
  localparam logic [7:0] XLAT [128] = '{
    8'hFF,8'h43,8'h41,8'h3F,8'h3D,8'h3B,8'h3C,8'h58,8'h64,8'h44,8'h42,8'h40,8'h3E,8'h0F,8'h29,8'h59,
    8'h65,8'h38,8'h2A,8'h70,8'h1D,8'h10,8'h02,8'h5A,8'h66,8'h71,8'h2C,8'h1F,8'h1E,8'h11,8'h03,8'h5B,
    8'h67,8'h2E,8'h2D,8'h20,8'h12,8'h05,8'h04,8'h5C,8'h68,8'h39,8'h2F,8'h21,8'h14,8'h13,8'h06,8'h5D,
    8'h69,8'h31,8'h30,8'h23,8'h22,8'h15,8'h07,8'h5E,8'h6A,8'h72,8'h32,8'h24,8'h16,8'h08,8'h09,8'h5F,
    8'h6B,8'h33,8'h25,8'h17,8'h18,8'h0B,8'h0A,8'h60,8'h6C,8'h34,8'h35,8'h26,8'h27,8'h19,8'h0C,8'h61,
    8'h6D,8'h73,8'h28,8'h74,8'h1A,8'h0D,8'h62,8'h6D,8'h3A,8'h36,8'h1C,8'h1B,8'h75,8'h2B,8'h63,8'h76,
    8'h55,8'h56,8'h77,8'h78,8'h79,8'h7A,8'h0E,8'h7B,8'h7C,8'h4F,8'h7D,8'h4B,8'h47,8'h7E,8'h7F,8'h6F,
    8'h52,8'h53,8'h50,8'h4C,8'h4D,8'h48,8'h01,8'h45,8'h57,8'h4E,8'h51,8'h4A,8'h37,8'h49,8'h46,8'h54};
endpackage : kmc_pkg

/* File: kmc_top.sv */
// keyboard and mouse port controller: links, fifo and host port
`timescale 1ns/10ps

// ***************
// fifo
// ***************
module kmc_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 32
) (
  input  wire logic         sys_clk_i,  // clock
  input  wire logic         sys_rst_i,  // sync reset
  input  wire logic         wr_valid_i, // push
  output logic              wr_ready_o, // not full
  input  wire logic [W-1:0] wr_data_i,  // push data
  output logic              rd_valid_o, // not empty
  input  wire logic         rd_ready_i, // pop
  output logic      [W-1:0] rd_data_o   // head word
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wptr;
    logic [AW:0] rptr;
  } kmc_fifo_reg_t;
  kmc_fifo_reg_t        r_reg, r_next;
  logic         [W-1:0] mem [DEPTH];
  logic                 push, pop;

  assign wr_ready_o = !((r_reg.wptr[AW-1:0] == r_reg.rptr[AW-1:0]) &&
                        (r_reg.wptr[AW] != r_reg.rptr[AW]));
  assign rd_valid_o = (r_reg.wptr != r_reg.rptr);
  assign rd_data_o  = mem[r_reg.rptr[AW-1:0]];
  assign push       = wr_valid_i && wr_ready_o;
  assign pop        = rd_ready_i && rd_valid_o;

  always_comb begin
    r_next = r_reg;
    if (push) r_next.wptr = r_reg.wptr + 1'b1;
    if (pop) r_next.rptr = r_reg.rptr + 1'b1;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) r_reg <= '0;
    else r_reg <= r_next;
    if (push) mem[r_reg.wptr[AW-1:0]] <= wr_data_i;
  end
endmodule : kmc_fifo

// ***************
// serial link
// ***************
module kmc_link #(
  parameter int TIMER_W = 8
) (
  input  wire logic       sys_clk_i,   // clock
  input  wire logic       sys_rst_i,   // sync reset
  input  wire logic       disable_i,   // hold clock low
  input  wire logic       ps_clk_i,    // link clock in
  input  wire logic       ps_dat_i,    // link data in
  output logic            ps_clk_oe_o, // pull clock low
  output logic            ps_dat_oe_o, // pull data low
  output logic      [7:0] rx_data_o,   // received byte
  output logic            rx_rx_parity_error_o,   // parity bad
  output logic            rx_valid_o,  // byte held
  input  wire logic       rx_ready_i,  // byte taken
  input  wire logic [7:0] tx_data_i,   // byte to send
  input  wire logic       tx_valid_i,  // send request
  output logic            tx_ready_o,  // send accepted
  output logic            timeout_o    // timer expired
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001, ST_RX  = 6'b000010, ST_HOLD = 6'b000100,
    ST_INH  = 6'b001000, ST_TX  = 6'b010000, ST_ACK  = 6'b100000
  } kmc_link_st_t;
  typedef struct packed {
    kmc_link_st_t       st;
    logic               clk_s1, clk_s2, clk_s3, dat_s1, dat_s2;
    logic [3:0]         bits;
    logic [9:0]         shreg;
    logic [7:0]         tick;
    logic [TIMER_W-1:0] timer;
    logic [11:0]        inh;
    logic               clk_oe, dat_oe;
    logic [7:0]         rx_data;
    logic               rx_rx_parity_error, rx_valid, tx_ready, timeout;
  } kmc_link_reg_t;
  kmc_link_reg_t r, n;
  logic          fall, expired;

  assign fall        = r.clk_s3 && !r.clk_s2;
  assign expired     = (r.timer == {TIMER_W{1'b1}});
  assign ps_clk_oe_o = r.clk_oe;
  assign ps_dat_oe_o = r.dat_oe;
  assign rx_data_o   = r.rx_data;
  assign rx_rx_parity_error_o   = r.rx_rx_parity_error;
  assign rx_valid_o  = r.rx_valid;
  assign tx_ready_o  = r.tx_ready;
  assign timeout_o   = r.timeout;

  always_comb begin
    n          = r;
    n.clk_s1   = ps_clk_i;
    n.clk_s2   = r.clk_s1;
    n.clk_s3   = r.clk_s2;
    n.dat_s1   = ps_dat_i;
    n.dat_s2   = r.dat_s1;
    n.tx_ready = 1'b0;
    n.timeout  = 1'b0;
    n.tick     = (r.tick == 8'(kmc_pkg::TICK_CYC - 1)) ? 8'h00 : r.tick + 8'h01;
    if (r.tick == 8'(kmc_pkg::TICK_CYC - 1) && !expired)
      n.timer = r.timer + 1'b1;
    case (r.st)
      ST_IDLE: begin
        n.timer  = '0;
        n.clk_oe = disable_i;
        n.dat_oe = 1'b0;
        if (!disable_i && tx_valid_i) begin
          n.st       = ST_INH;
          n.inh      = 12'h000;
          n.clk_oe   = 1'b1;
          n.tx_ready = 1'b1;
          n.shreg    = {1'b1, ~^tx_data_i, tx_data_i};
        end else if (!disable_i && !r.clk_oe && fall && !r.dat_s2) begin
          n.st   = ST_RX;
          n.bits = 4'h0;
        end
      end
      ST_RX: begin
        if (expired) begin
          n.st      = ST_IDLE;
          n.timeout = 1'b1;
        end else if (fall && r.bits == 4'h9) begin
          n.st       = ST_HOLD;
          n.clk_oe   = 1'b1;
          n.rx_valid = 1'b1;
          n.rx_rx_parity_error  = ~^r.shreg[8:0];
          n.rx_data  = (~^r.shreg[8:0]) ? kmc_pkg::RX_PARITY_ERROR_BYTE
                                        : r.shreg[7:0];
        end else if (fall) begin
          n.shreg = {1'b0, r.dat_s2, r.shreg[8:1]};
          n.bits  = r.bits + 4'h1;
        end
      end
      ST_HOLD: begin
        n.clk_oe = 1'b1;
        if (rx_ready_i) begin
          n.rx_valid = 1'b0;
          n.clk_oe   = 1'b0;
          n.st       = ST_IDLE;
        end
      end
      ST_INH: begin
        n.inh = r.inh + 12'h001;
        if (r.inh == 12'(kmc_pkg::INHIBIT_CYC - 1)) begin
          n.st     = ST_TX;
          n.dat_oe = 1'b1;
          n.clk_oe = 1'b0;
          n.bits   = 4'h0;
          n.timer  = '0;
        end
      end
      ST_TX: begin
        if (expired) begin
          n.st      = ST_IDLE;
          n.dat_oe  = 1'b0;
          n.timeout = 1'b1;
        end else if (fall) begin
          n.dat_oe = !r.shreg[0];
          n.shreg  = {1'b1, r.shreg[9:1]};
          n.bits   = r.bits + 4'h1;
          if (r.bits == 4'h9) n.st = ST_ACK;
        end
      end
      ST_ACK: begin
        if (expired) begin
          n.st      = ST_IDLE;
          n.timeout = 1'b1;
        end else if (fall && !r.dat_s2) n.st = ST_IDLE;
      end
      default: n.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      r        <= '0;
      r.st     <= ST_IDLE;
      r.clk_s1 <= 1'b1;
      r.clk_s2 <= 1'b1;
      r.clk_s3 <= 1'b1;
    end else r <= n;
  end

  link_disable_a:
  assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    r.st == ST_IDLE && disable_i |=> ps_clk_oe_o)
    else $error("disabled link clock not held low");
  rx_parity_error_byte_a:
  assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(rx_valid_o) && rx_rx_parity_error_o |-> rx_data_o == kmc_pkg::RX_PARITY_ERROR_BYTE)
    else $error("parity error byte not FF");
  timer_expiry_a:
  assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    timeout_o |-> $past(r.timer) == {TIMER_W{1'b1}})
    else $error("timeout without full timer");
  start_bit_a:
  assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    r.st == ST_INH && r.inh == 12'(kmc_pkg::INHIBIT_CYC - 1)
    |=> ps_dat_oe_o && !ps_clk_oe_o)
    else $error("start bit not driven low");
  rx_frame_c: cover property (@(posedge sys_clk_i) $rose(rx_valid_o));
  tx_frame_c: cover property (@(posedge sys_clk_i) r.st == ST_ACK ##1 r.st == ST_IDLE);
endmodule : kmc_link

// ***************
// controller top
// ***************
module kmc_top (
  input  wire logic       sys_clk_i,    // clock
  input  wire logic       sys_rst_i,    // sync reset
  input  wire logic [7:0] io_addr_i,    // io address
  input  wire logic       io_rd_i,      // read strobe
  input  wire logic       io_wr_i,      // write strobe
  input  wire logic [7:0] io_wdata_i,   // write data
  output logic      [7:0] io_rdata_o,   // read data
  output logic            kbd_irq_o,    // keyboard interrupt
  output logic            aux_irq_o,    // mouse interrupt
  input  wire logic       kbd_clk_i,    // keyboard clock in
  output logic            kbd_clk_o,    // keyboard clock out
  output logic            kbd_clk_oe_o, // keyboard clock drive
  input  wire logic       kbd_dat_i,    // keyboard data in
  output logic            kbd_dat_o,    // keyboard data out
  output logic            kbd_dat_oe_o, // keyboard data drive
  input  wire logic       aux_clk_i,    // mouse clock in
  output logic            aux_clk_o,    // mouse clock out
  output logic            aux_clk_oe_o, // mouse clock drive
  input  wire logic       aux_dat_i,    // mouse data in
  output logic            aux_dat_o,    // mouse data out
  output logic            aux_dat_oe_o, // mouse data drive
  input  wire logic [7:0] in_port_i,    // parallel port 1
  output logic      [7:0] out_port_o    // parallel port 2
);
  typedef enum logic [3:0] {
    PEND_NONE = 4'b0001, PEND_RAM = 4'b0010,
    PEND_OUT  = 4'b0100, PEND_AUX = 4'b1000
  } kmc_pend_t;
  typedef struct packed {
    kmc_pend_t  pend;
    logic [4:0] ram_idx;
    logic [7:0] ib, ob, resp, mode, rdata, out_port, in_s1, in_s2;
    logic       in_buffer_full, cd, out_buffer_full, ods, rx_parity_error, terr, resp_v, brk, kbd_interrupt_line, airq;
  } kmc_top_reg_t;
  kmc_top_reg_t r, n;
  logic [7:0]   ram_mem [1:31];
  logic         ram_we, kbd_tx_v, aux_tx_v, fifo_pop, fifo_rd_v, fifo_wr_rdy;
  logic [9:0]   fifo_wdata, fifo_rdata;
  logic [7:0]   kbd_rx_data, aux_rx_data, status;
  logic         kbd_rx_v, aux_rx_v, kbd_rx_rx_parity_error, aux_rx_rx_parity_error;
  logic         kbd_push, aux_push, kbd_tx_rdy, aux_tx_rdy, kbd_to, aux_to;

  assign kbd_clk_o  = 1'b0;
  assign kbd_dat_o  = 1'b0;
  assign aux_clk_o  = 1'b0;
  assign aux_dat_o  = 1'b0;
  assign io_rdata_o = r.rdata;
  assign kbd_irq_o  = r.kbd_interrupt_line;
  assign aux_irq_o  = r.airq;
  assign out_port_o = r.out_port;
  assign kbd_push   = kbd_rx_v && fifo_wr_rdy;
  assign aux_push   = aux_rx_v && fifo_wr_rdy && !kbd_rx_v;
  assign fifo_wdata = kbd_rx_v ? {1'b0, kbd_rx_rx_parity_error, kbd_rx_data}
                               : {1'b1, aux_rx_rx_parity_error, aux_rx_data};
  assign status = {r.rx_parity_error, r.terr, r.ods, r.in_s2[7], r.cd,
                   r.mode[kmc_pkg::MODE_WARM], r.in_buffer_full, r.out_buffer_full};

  kmc_link #(.TIMER_W(8)) u_kbd_link (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .disable_i(r.mode[kmc_pkg::MODE_KDIS]),
    .ps_clk_i(kbd_clk_i), .ps_dat_i(kbd_dat_i),
    .ps_clk_oe_o(kbd_clk_oe_o), .ps_dat_oe_o(kbd_dat_oe_o),
    .rx_data_o(kbd_rx_data), .rx_rx_parity_error_o(kbd_rx_rx_parity_error),
    .rx_valid_o(kbd_rx_v), .rx_ready_i(kbd_push),
    .tx_data_i(r.ib), .tx_valid_i(kbd_tx_v), .tx_ready_o(kbd_tx_rdy),
    .timeout_o(kbd_to));
  kmc_link #(.TIMER_W(8)) u_aux_link (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .disable_i(r.mode[kmc_pkg::MODE_ADIS]),
    .ps_clk_i(aux_clk_i), .ps_dat_i(aux_dat_i),
    .ps_clk_oe_o(aux_clk_oe_o), .ps_dat_oe_o(aux_dat_oe_o),
    .rx_data_o(aux_rx_data), .rx_rx_parity_error_o(aux_rx_rx_parity_error),
    .rx_valid_o(aux_rx_v), .rx_ready_i(aux_push),
    .tx_data_i(r.ib), .tx_valid_i(aux_tx_v), .tx_ready_o(aux_tx_rdy),
    .timeout_o(aux_to));
  kmc_fifo #(.W(10), .DEPTH(32)) u_fifo (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .wr_valid_i(kbd_rx_v || aux_rx_v), .wr_ready_o(fifo_wr_rdy),
    .wr_data_i(fifo_wdata), .rd_valid_o(fifo_rd_v),
    .rd_ready_i(fifo_pop), .rd_data_o(fifo_rdata));

  always_comb begin
    n        = r;
    ram_we   = 1'b0;
    kbd_tx_v = 1'b0;
    aux_tx_v = 1'b0;
    fifo_pop = 1'b0;
    n.in_s1  = in_port_i;
    n.in_s2  = r.in_s1;
    // command and data consumption
    if (r.in_buffer_full && r.cd && !r.resp_v) begin
      n.in_buffer_full = 1'b0;
      n.cd  = 1'b0;
      if (r.ib >= kmc_pkg::CMD_RAM_RD && r.ib <= kmc_pkg::CMD_RAM_RDE) begin
        n.resp_v = 1'b1;
        n.resp   = (r.ib[4:0] == 5'h00) ? (r.mode & kmc_pkg::MODE_MASK)
                                        : ram_mem[r.ib[4:0]];
      end else if (r.ib >= kmc_pkg::CMD_RAM_WR &&
                   r.ib <= kmc_pkg::CMD_RAM_WRE) begin
        n.pend    = PEND_RAM;
        n.ram_idx = r.ib[4:0];
      end else begin
        case (r.ib)
          kmc_pkg::CMD_KBD_OFF: n.mode[kmc_pkg::MODE_KDIS] = 1'b1;
          kmc_pkg::CMD_KBD_ON:  n.mode[kmc_pkg::MODE_KDIS] = 1'b0;
          kmc_pkg::CMD_AUX_OFF: n.mode[kmc_pkg::MODE_ADIS] = 1'b1;
          kmc_pkg::CMD_AUX_ON:  n.mode[kmc_pkg::MODE_ADIS] = 1'b0;
          kmc_pkg::CMD_IN_RD: begin
            n.resp_v = 1'b1;
            n.resp   = r.in_s2;
          end
          kmc_pkg::CMD_OUT_RD: begin
            n.resp_v = 1'b1;
            n.resp   = r.out_port;
          end
          kmc_pkg::CMD_OUT_WR: n.pend = PEND_OUT;
          kmc_pkg::CMD_AUX_TX: n.pend = PEND_AUX;
          default: n.pend = PEND_NONE;
        endcase
      end
    end else if (r.in_buffer_full && !r.cd) begin
      case (r.pend)
        PEND_RAM: begin
          n.in_buffer_full  = 1'b0;
          n.pend = PEND_NONE;
          if (r.ram_idx == 5'h00) n.mode = r.ib & kmc_pkg::MODE_MASK;
          else ram_we = 1'b1;
        end
        PEND_OUT: begin
          n.in_buffer_full      = 1'b0;
          n.pend     = PEND_NONE;
          n.out_port = r.ib;
        end
        PEND_AUX: begin
          aux_tx_v = 1'b1;
          if (aux_tx_rdy) begin
            n.in_buffer_full  = 1'b0;
            n.pend = PEND_NONE;
          end
        end
        default: begin
          kbd_tx_v = 1'b1;
          if (kbd_tx_rdy) n.in_buffer_full = 1'b0;
        end
      endcase
    end
    // host reads, address decode
    if (io_rd_i) begin
      if (io_addr_i == kmc_pkg::ADR_DATA) begin
        n.rdata = r.ob;
        n.out_buffer_full   = 1'b0;
      end else if (io_addr_i == kmc_pkg::ADR_CMD) n.rdata = status;
      else n.rdata = kmc_pkg::ADR_NONE;
    end
    // output buffer load, command answers first
    if (!r.out_buffer_full) begin
      if (r.resp_v) begin
        n.ob     = r.resp;
        n.out_buffer_full    = 1'b1;
        n.ods    = 1'b0;
        n.resp_v = 1'b0;
      end else if (fifo_rd_v) begin
        fifo_pop = 1'b1;
        if (!fifo_rdata[9] && !fifo_rdata[8] && r.mode[kmc_pkg::MODE_XLAT] &&
            fifo_rdata[7:0] == kmc_pkg::BREAK_PFX) n.brk = 1'b1;
        else begin
          n.ob = fifo_rdata[7:0];
          if (!fifo_rdata[9] && !fifo_rdata[8] && !fifo_rdata[7] &&
              r.mode[kmc_pkg::MODE_XLAT])
            n.ob = kmc_pkg::XLAT[fifo_rdata[6:0]] | {r.brk, 7'h00};
          if (!fifo_rdata[9]) n.brk = 1'b0;
          n.out_buffer_full  = 1'b1;
          n.ods  = fifo_rdata[9];
          n.rx_parity_error = fifo_rdata[8];
          n.terr = 1'b0;
        end
      end
    end
    if (kbd_to || aux_to) n.terr = 1'b1;
    // host writes win over consumption
    if (io_wr_i && io_addr_i == kmc_pkg::ADR_CMD) begin
      n.ib  = io_wdata_i;
      n.in_buffer_full = 1'b1;
      n.cd  = 1'b1;
    end else if (io_wr_i && io_addr_i == kmc_pkg::ADR_DATA) begin
      n.ib  = io_wdata_i;
      n.in_buffer_full = 1'b1;
      n.cd  = 1'b0;
    end
    n.kbd_interrupt_line = n.out_buffer_full && !n.ods && n.mode[kmc_pkg::MODE_KIE];
    n.airq = n.out_buffer_full && n.ods && n.mode[kmc_pkg::MODE_AIE];
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      r          <= '0;
      r.pend     <= PEND_NONE;
      r.mode     <= kmc_pkg::MODE_RESET;
      r.out_port <= kmc_pkg::OUT_RESET;
    end else r <= n;
    if (ram_we) ram_mem[r.ram_idx] <= r.ib;
  end

  obf_clear_a:
  assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    io_rd_i && io_addr_i == kmc_pkg::ADR_DATA && r.out_buffer_full |=> !r.out_buffer_full)
    else $error("output-full not cleared by data read");
  ibf_set_a:
  assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    io_wr_i && (io_addr_i == kmc_pkg::ADR_DATA ||
                io_addr_i == kmc_pkg::ADR_CMD) |=> r.in_buffer_full)
    else $error("input-full not set by host write");
  sys_flag_a:
  assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    io_rd_i && io_addr_i == kmc_pkg::ADR_CMD
    |=> io_rdata_o[2] == $past(r.mode[kmc_pkg::MODE_WARM]))
    else $error("system flag differs from mode bit");
  mode_resv_a:
  assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    r.mode[3] == 1'b0 && r.mode[7] == 1'b0)
    else $error("reserved mode bit set");
  kbd_irq_a:
  assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    kbd_irq_o == (r.out_buffer_full && !r.ods && r.mode[kmc_pkg::MODE_KIE]))
    else $error("keyboard interrupt wrong");
  aux_irq_a:
  assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    aux_irq_o == (r.out_buffer_full && r.ods && r.mode[kmc_pkg::MODE_AIE]))
    else $error("mouse interrupt wrong");
  mode_read_a:
  assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    r.in_buffer_full && r.cd && !r.resp_v && r.ib == kmc_pkg::CMD_RAM_RD
    |=> r.resp_v && r.resp == $past(r.mode))
    else $error("command 20 did not return mode");
  mode_read_c: cover property (@(posedge sys_clk_i)
    r.resp_v ##[1:4] r.out_buffer_full);
  fifo_full_c: cover property (@(posedge sys_clk_i) !fifo_wr_rdy);
endmodule : kmc_top

/* File: kmc_dev.sv */
// serial device model for one link
`timescale 1ns/10ps
module kmc_dev (
  input  wire logic clk_oe_i, // host pulls clock
  input  wire logic dat_oe_i, // host pulls data
  output logic      clk_o,    // clock wire
  output logic      dat_o     // data wire
);
  logic        clk_d = 1'b1;
  logic        dat_d = 1'b1;
  logic [10:0] fr;
  // pull-ups give one when released
  assign clk_o = ~clk_oe_i & clk_d;
  assign dat_o = ~dat_oe_i & dat_d;
  task automatic send(input logic [7:0] b, input logic bad);
    fr = {1'b1, ~^b ^ bad, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      dat_d = fr[i];
      #160 clk_d = 1'b0;
      #160 clk_d = 1'b1;
    end
    dat_d = 1'b1;
  endtask : send
  task automatic recv(output logic [10:0] f);
    for (int i = 0; i < 3000 && !(dat_oe_i && !clk_oe_i); i++) #40;
    f[0] = dat_o;
    for (int i = 1; i < 12; i++) begin
      #160 clk_d = 1'b0;
      #160 clk_d = 1'b1;
      if (i < 11) f[i] = dat_o;
      if (i == 10) dat_d = 1'b0;
    end
    dat_d = 1'b1;
  endtask : recv
endmodule : kmc_dev

/* File: kmc_tb.sv */
// self-checking bench of the port controller
`timescale 1ns/10ps
module testbench;
  logic       sys_clk_i, sys_rst_i, io_rd, io_wr, kbd_interrupt_line, airq;
  logic       kco, kdo, aco, ado, kc, kd, ac, ad;
  logic [7:0] io_addr, io_wdata, io_rdata, out_port, q, st;
  logic       irq;
  logic [7:0] in_port;
  int         miscompares, cmp_count;
  kmc_top u_kmc_top (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .io_addr_i(io_addr), .io_rd_i(io_rd), .io_wr_i(io_wr),
    .io_wdata_i(io_wdata), .io_rdata_o(io_rdata), .kbd_irq_o(kbd_interrupt_line),
    .aux_irq_o(airq), .kbd_clk_i(kc), .kbd_clk_o(), .kbd_clk_oe_o(kco),
    .kbd_dat_i(kd), .kbd_dat_o(), .kbd_dat_oe_o(kdo), .aux_clk_i(ac),
    .aux_clk_o(), .aux_clk_oe_o(aco), .aux_dat_i(ad), .aux_dat_o(),
    .aux_dat_oe_o(ado), .in_port_i(in_port), .out_port_o(out_port));
  kmc_dev u_kmc_dev_kbd (.clk_oe_i(kco), .dat_oe_i(kdo), .clk_o(kc),
    .dat_o(kd));
  kmc_dev u_kmc_dev_aux (.clk_oe_i(aco), .dat_oe_i(ado), .clk_o(ac),
    .dat_o(ad));
  // ***************
  // shared tasks
  // ***************
  task automatic give_verdict();
    if (miscompares == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask : chk
  task automatic acc(input logic [7:0] a, input logic w,
                     input logic [7:0] d, output logic [7:0] r);
    @(posedge sys_clk_i);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= w;
    io_rd    <= ~w;
    @(posedge sys_clk_i);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    #1 r = io_rdata;
  endtask : acc
  task automatic wait_st(input logic [7:0] m, v);
    logic [7:0] s;
    for (int i = 0; i < 400; i++) begin
      acc(8'h64, 1'b0, 8'h00, s);
      if ((s & m) === v) return;
    end
    miscompares++;
    give_verdict();
  endtask : wait_st
  task automatic wr(input logic [7:0] a, d);
    acc(a, 1'b1, d, q);
    wait_st(8'h02, 8'h00);
  endtask : wr
  task automatic get(input logic [7:0] c);
    wr(8'h64, c);
    wait_st(8'h01, 8'h01);
    acc(8'h60, 1'b0, 8'h00, q);
  endtask : get
  task automatic rx(input logic [7:0] m, b, input logic bad, aux);
    wr(8'h64, 8'h60);
    wr(8'h60, m);
    if (aux) u_kmc_dev_aux.send(b, bad);
    else u_kmc_dev_kbd.send(b, bad);
    wait_st(8'h01, 8'h01);
    acc(8'h64, 1'b0, 8'h00, st);
    irq = aux ? airq : kbd_interrupt_line;
    acc(8'h60, 1'b0, 8'h00, q);
  endtask : rx
  // ***************
  // scenarios
  // ***************
  task automatic t_reset();
    acc(8'h64, 1'b0, 8'h00, q);
    chk("status", 8'h10, q);
    chk("out_port", 8'h00, out_port);
  endtask : t_reset
  task automatic t_mode();
    wr(8'h64, 8'h60);
    wr(8'h60, 8'hFF);
    acc(8'h64, 1'b0, 8'h00, q);
    chk("status", 8'h14, q);
    chk("clk_oe", 8'h03, {kco, aco});
    get(8'h20);
    chk("mode", 8'h77, q);
  endtask : t_mode
  task automatic t_ram_port();
    wr(8'h64, 8'h7F);
    wr(8'h60, 8'h5A);
    get(8'h3F);
    chk("ram", 8'h5A, q);
    wr(8'h64, 8'hD1);
    wr(8'h60, 8'hC3);
    chk("out_port", 8'hC3, out_port);
    get(8'hD0);
    chk("out_rd", 8'hC3, q);
    @(posedge sys_clk_i);
    in_port <= 8'hA5;
    get(8'hC0);
    chk("in_rd", 8'hA5, q);
  endtask : t_ram_port
  task automatic t_links();
    rx(8'h01, 8'h1C, 1'b0, 1'b0);
    chk("kbd_data", 8'h1C, q);
    chk("kbd_irq", 8'h01, irq);
    acc(8'h64, 1'b0, 8'h00, q);
    chk("obf", 8'h00, q & 8'h01);
    rx(8'h40, 8'h1C, 1'b0, 1'b0);
    chk("xlat", 8'h1E, q);
    rx(8'h01, 8'h55, 1'b1, 1'b0);
    chk("rx_parity_error_data", 8'hFF, q);
    chk("rx_parity_error_st", 8'h81, st & 8'h81);
    chk("rx_parity_error_irq", 8'h01, irq);
    rx(8'h02, 8'hA3, 1'b0, 1'b1);
    chk("aux_data", 8'hA3, q);
    chk("aux_irq", 8'h01, irq);
  endtask : t_links
  task automatic t_cmds();
    wr(8'h64, 8'hAD);
    wr(8'h64, 8'hA7);
    chk("cmd_off", 8'h03, {kco, aco});
    wr(8'h64, 8'hAE);
    wr(8'h64, 8'hA8);
    chk("cmd_on", 8'h00, {kco, aco});
  endtask : t_cmds
  task automatic t_tx(input logic [7:0] b, input logic aux);
    logic [10:0] f;
    if (aux) wr(8'h64, 8'hD4);
    wr(8'h60, b);
    if (aux) u_kmc_dev_aux.recv(f);
    else u_kmc_dev_kbd.recv(f);
    chk("tx_data", b, f[8:1]);
    chk("tx_frame", {5'h00, 1'b1, ~^b, 1'b0}, {5'h00, f[10:9], f[0]});
    chk("tx_idle", 8'h00, {kdo, ado});
  endtask : t_tx
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    miscompares = 0;
    cmp_count   = 0;
    sys_rst_i   = 1'b1;
    io_addr     = 8'h00;
    io_wdata    = 8'h00;
    io_rd       = 1'b0;
    io_wr       = 1'b0;
    in_port     = 8'h80;
    repeat (4) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    t_reset();
    t_mode();
    t_ram_port();
    t_links();
    t_cmds();
    t_tx(8'hED, 1'b0);
    t_tx(8'hF4, 1'b1);
    give_verdict();
  end
endmodule : testbench
